// [rtl/pcd_consts.vh]
`ifndef PCD_CONSTS_VH
`define PCD_CONSTS_VH
// Register offsets (word index on the plain register port)
`define PCD_A_C_DATA 4'h0
`define PCD_A_C_IOEN 4'h1
`define PCD_A_C_RCTL 4'h2
`define PCD_A_C_INTF 4'h3
`define PCD_A_C_INTCTL 4'h4
`define PCD_A_C_CHATEN 4'h5
`define PCD_A_C_MODSEL 4'h6
`define PCD_A_C_FNCSEL 4'h7
`define PCD_A_D_DATA 4'h8
`define PCD_A_D_IOEN 4'h9
`define PCD_A_D_RCTL 4'ha
`define PCD_A_D_INTF 4'hb
`define PCD_A_D_MODSEL 4'hc
`define PCD_A_D_FNCSEL 4'hd
`define PCD_A_IRQ_GRP 4'he
`define PCD_A_IRQ_MASK 4'hf
// Reset values and fixed read values
`define PCD_RST_BYTE 8'h00
`define PCD_RST_DMODE 5'h07
`define PCD_RST_DFNC 10'h000
`define PCD_RST_DFIVE 5'h00
`define PCD_FNC_C_RO 16'haaaa
`define PCD_ZERO16 16'h0000
// Package variants
`define PCD_PKG_64 2'h0
`define PCD_PKG_80 2'h1
`define PCD_PKG_100 2'h2
// Pin masks
`define PCD_MASK_ALL 8'hff
`define PCD_MASK_80 8'h1f
`define PCD_MASK_NONE 8'h00
`define PCD_D_MASK_NOP2 5'h1b
`define PCD_D_P2 2
// Group summary bit position
`define PCD_GRP_BIT 3
`endif

// [rtl/pcd_sync2.v]
`timescale 1ns/1ns
// Two-stage synchroniser for a bus of pin levels
module pcd_sync2 #(
  parameter W = 8
) (
  input wire ref_clk_i,     // System clock
  input wire rstn_i,        // Async reset, active low
  input wire [W-1:0] d_i,   // Asynchronous levels
  output reg [W-1:0] q_o    // Synchronised levels
);
  reg [W-1:0] meta;

  // First stage is read only by the second
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // pcd_sync2

// [rtl/pcd_port.v]
`timescale 1ns/1ns
`include "pcd_consts.vh"
module pcd_port #(
  parameter [1:0] PKG = `PCD_PKG_100
) (
  input wire ref_clk_i,              // System clock, 125 MHz
  input wire rstn_i,                 // Async reset, active low
  input wire [3:0] addr_i,           // Register word index
  input wire [15:0] wdata_i,         // Write data
  input wire wr_i,                   // Write strobe
  input wire rd_i,                   // Read strobe
  output reg [15:0] rdata_o,         // Read data, cycle after strobe
  output wire irq_o,                 // Level interrupt
  input wire [7:0] grp_c_pin_i,      // Group C pin levels
  output reg [7:0] grp_c_pin_o,      // Group C pin drive value
  output reg [7:0] grp_c_pin_oe_o,   // Group C pin output enable
  output reg [7:0] grp_c_pull_en_o,  // Group C pull enable
  output reg [7:0] grp_c_pull_up_o,  // Group C pull direction, 1 up
  output wire [15:0] grp_c_function_select_o, // Group C function fields
  input wire [31:0] grp_c_fn_out_i,  // Group C per-function drive value, 4 per pin
  input wire [31:0] grp_c_fn_oe_i,   // Group C per-function output enable
  input wire [4:0] dbg_pin_i,        // Debug group pin levels
  output reg [4:0] dbg_pin_o,        // Debug group drive value
  output reg [4:0] dbg_pin_oe_o,     // Debug group output enable
  output reg [4:0] dbg_pull_en_o,    // Debug group pull enable
  output reg [4:0] dbg_pull_up_o,    // Debug group pull direction
  output reg [4:0] dbg_fn_in_o,      // Debug group inputs to peripherals
  input wire [19:0] dbg_fn_out_i,    // Debug group per-function drive value
  input wire [19:0] dbg_fn_oe_i,     // Debug group per-function output enable
  output wire grp_c_group_irq_o      // Group C summary flag
);
  // ******************************************************
  // Variant masks
  // ******************************************************
  // variant pin mask
  wire [7:0] cm = (PKG == `PCD_PKG_64) ? `PCD_MASK_NONE :
                  (PKG == `PCD_PKG_80) ? `PCD_MASK_80 : `PCD_MASK_ALL;

  // ******************************************************
  // Registers
  // ******************************************************
  reg [7:0] grp_c_out_value;
  reg [7:0] grp_c_input_enable;
  reg [7:0] grp_c_output_enable;
  reg [7:0] grp_c_pull_direction;
  reg [7:0] grp_c_pull_enable;
  reg [7:0] grp_c_irq_flag;
  reg [7:0] grp_c_edge_select;
  reg [7:0] grp_c_irq_enable;
  reg [7:0] grp_c_mode_select;
  reg [4:0] dbg_grp_out_value;
  reg [4:0] dbg_grp_input_enable;
  reg [4:0] dbg_grp_output_enable;
  reg [4:0] dbg_grp_pull_direction;
  reg [4:0] dbg_grp_pull_enable;
  reg [4:0] dbg_grp_mode_select;
  reg [9:0] dbg_grp_function;
  reg [7:0] irq_status;
  reg [7:0] irq_mask;
  reg [7:0] c_prev;
  wire [7:0] c_sync;
  wire [4:0] d_sync;
  wire [7:0] grp_c_in_value;
  wire [4:0] dbg_grp_in_value;
  wire [7:0] c_edge;
  wire [7:0] c_flag_set;
  wire wr_flags;
  wire rd_status;
  wire [7:0] stat_set;

  // ******************************************************
  // Pin synchronisers
  // ******************************************************
  pcd_sync2 #(.W(8)) u_sync_c (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .d_i(grp_c_pin_i),
    .q_o(c_sync)
  );

  pcd_sync2 #(.W(5)) u_sync_d (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .d_i(dbg_pin_i),
    .q_o(d_sync)
  );

  // Input values gated by input enable
  // per-pin input, bits masked
  assign grp_c_in_value = c_sync & grp_c_input_enable & cm;
  assign dbg_grp_in_value = d_sync & dbg_grp_input_enable & `PCD_D_MASK_NOP2;

  // ******************************************************
  // Edge detection and interrupts
  // ******************************************************
  // edge per select, 1 falling
  assign c_edge = (grp_c_in_value & ~c_prev & ~grp_c_edge_select) |
                  (~grp_c_in_value & c_prev & grp_c_edge_select);
  assign c_flag_set = c_edge & cm;
  assign wr_flags = wr_i && (addr_i == `PCD_A_C_INTF);
  assign rd_status = rd_i && (addr_i == `PCD_A_IRQ_GRP);
  assign grp_c_group_irq_o = |(grp_c_irq_flag & grp_c_irq_enable & cm);
  assign stat_set = {4'h0, grp_c_group_irq_o, 3'h0};
  assign irq_o = |(irq_status & irq_mask);
  assign grp_c_function_select_o = `PCD_FNC_C_RO;

  // Previous input, flags and summary status
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      c_prev <= `PCD_RST_BYTE;
      grp_c_irq_flag <= `PCD_RST_BYTE;
      irq_status <= `PCD_RST_BYTE;
    end else begin
      c_prev <= grp_c_in_value;
      if (wr_flags) begin
        grp_c_irq_flag <= ((grp_c_irq_flag & ~wdata_i[7:0]) | c_flag_set) & cm;
      end else begin
        grp_c_irq_flag <= (grp_c_irq_flag | c_flag_set) & cm;
      end
      // Read of status clears, new event wins
      if (rd_status) begin
        irq_status <= stat_set;
      end else begin
        irq_status <= irq_status | stat_set;
      end
    end
  end

  // ******************************************************
  // Register writes
  // ******************************************************
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      grp_c_out_value <= `PCD_RST_BYTE;
      grp_c_input_enable <= `PCD_RST_BYTE;
      grp_c_output_enable <= `PCD_RST_BYTE;
      grp_c_pull_direction <= `PCD_RST_BYTE;
      grp_c_pull_enable <= `PCD_RST_BYTE;
      grp_c_edge_select <= `PCD_RST_BYTE;
      grp_c_irq_enable <= `PCD_RST_BYTE;
      grp_c_mode_select <= `PCD_RST_BYTE;
      dbg_grp_out_value <= `PCD_RST_DFIVE;
      dbg_grp_input_enable <= `PCD_RST_DFIVE;
      dbg_grp_output_enable <= `PCD_RST_DFIVE;
      dbg_grp_pull_direction <= `PCD_RST_DFIVE;
      dbg_grp_pull_enable <= `PCD_RST_DFIVE;
      dbg_grp_mode_select <= `PCD_RST_DMODE;
      dbg_grp_function <= `PCD_RST_DFNC;
      irq_mask <= `PCD_RST_BYTE;
    end else if (wr_i) begin
      case (addr_i)
        `PCD_A_C_DATA: begin
          grp_c_out_value <= wdata_i[15:8] & cm;
        end
        `PCD_A_C_IOEN: begin
          grp_c_input_enable <= wdata_i[15:8] & cm;
          grp_c_output_enable <= wdata_i[7:0] & cm;
        end
        `PCD_A_C_RCTL: begin
          grp_c_pull_direction <= wdata_i[15:8] & cm;
          grp_c_pull_enable <= wdata_i[7:0] & cm;
        end
        `PCD_A_C_INTCTL: begin
          grp_c_edge_select <= wdata_i[15:8] & cm;
          grp_c_irq_enable <= wdata_i[7:0] & cm;
        end
        `PCD_A_C_MODSEL: begin
          grp_c_mode_select <= wdata_i[7:0] & cm;
        end
        `PCD_A_D_DATA: begin
          dbg_grp_out_value <= wdata_i[12:8];
        end
        `PCD_A_D_IOEN: begin
          dbg_grp_input_enable <= wdata_i[12:8];
          dbg_grp_output_enable <= wdata_i[4:0];
        end
        `PCD_A_D_RCTL: begin
          dbg_grp_pull_direction <= wdata_i[12:8];
          dbg_grp_pull_enable <= wdata_i[4:0] & `PCD_D_MASK_NOP2;
        end
        `PCD_A_D_MODSEL: begin
          dbg_grp_mode_select <= wdata_i[4:0];
        end
        `PCD_A_D_FNCSEL: begin
          dbg_grp_function <= wdata_i[9:0];
        end
        `PCD_A_IRQ_MASK: begin
          irq_mask <= wdata_i[7:0];
        end
        default: begin
          irq_mask <= irq_mask;
        end
      endcase
    end
  end

  // ******************************************************
  // Register reads
  // ******************************************************
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= `PCD_ZERO16;
    end else if (rd_i) begin
      case (addr_i)
        `PCD_A_C_DATA: rdata_o <= {grp_c_out_value, grp_c_in_value};
        `PCD_A_C_IOEN: rdata_o <= {grp_c_input_enable, grp_c_output_enable};
        `PCD_A_C_RCTL: rdata_o <= {grp_c_pull_direction, grp_c_pull_enable};
        `PCD_A_C_INTF: rdata_o <= {8'h00, grp_c_irq_flag};
        `PCD_A_C_INTCTL: rdata_o <= {grp_c_edge_select, grp_c_irq_enable};
        `PCD_A_C_CHATEN: rdata_o <= `PCD_ZERO16;
        `PCD_A_C_MODSEL: rdata_o <= {8'h00, grp_c_mode_select};
        `PCD_A_C_FNCSEL: rdata_o <= `PCD_FNC_C_RO;
        `PCD_A_D_DATA: rdata_o <= {3'h0, dbg_grp_out_value, 3'h0, dbg_grp_in_value};
        `PCD_A_D_IOEN: rdata_o <= {3'h0, dbg_grp_input_enable, 3'h0, dbg_grp_output_enable};
        `PCD_A_D_RCTL: rdata_o <= {3'h0, dbg_grp_pull_direction, 3'h0, dbg_grp_pull_enable};
        `PCD_A_D_INTF: rdata_o <= `PCD_ZERO16;
        `PCD_A_D_MODSEL: rdata_o <= {11'h000, dbg_grp_mode_select};
        `PCD_A_D_FNCSEL: rdata_o <= {6'h00, dbg_grp_function};
        `PCD_A_IRQ_GRP: rdata_o <= {8'h00, irq_status};
        `PCD_A_IRQ_MASK: rdata_o <= {8'h00, irq_mask};
        default: rdata_o <= `PCD_ZERO16;
      endcase
    end else begin
      rdata_o <= `PCD_ZERO16;
    end
  end

  // ******************************************************
  // Pin drive multiplexers
  // ******************************************************
  integer i;
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      grp_c_pin_o <= `PCD_RST_BYTE;
      grp_c_pin_oe_o <= `PCD_RST_BYTE;
      grp_c_pull_en_o <= `PCD_RST_BYTE;
      grp_c_pull_up_o <= `PCD_RST_BYTE;
      dbg_pin_o <= `PCD_RST_DFIVE;
      dbg_pin_oe_o <= `PCD_RST_DFIVE;
      dbg_pull_en_o <= `PCD_RST_DFIVE;
      dbg_pull_up_o <= `PCD_RST_DFIVE;
      dbg_fn_in_o <= `PCD_RST_DFIVE;
    end else begin
      for (i = 0; i < 8; i = i + 1) begin
        if (grp_c_mode_select[i]) begin
          grp_c_pin_o[i] <= grp_c_fn_out_i[i*4 + 2] & cm[i];
          grp_c_pin_oe_o[i] <= grp_c_fn_oe_i[i*4 + 2] & cm[i];
        end else begin
          grp_c_pin_o[i] <= grp_c_out_value[i];
          grp_c_pin_oe_o[i] <= grp_c_output_enable[i];
        end
      end
      grp_c_pull_en_o <= grp_c_pull_enable & ~grp_c_mode_select;
      grp_c_pull_up_o <= grp_c_pull_direction;
      for (i = 0; i < 5; i = i + 1) begin
        if (dbg_grp_mode_select[i]) begin
          dbg_pin_o[i] <= dbg_fn_out_i[i*4 + dbg_grp_function[i*2 +: 2]];
          dbg_pin_oe_o[i] <= dbg_fn_oe_i[i*4 + dbg_grp_function[i*2 +: 2]];
        end else begin
          dbg_pin_o[i] <= dbg_grp_out_value[i];
          dbg_pin_oe_o[i] <= dbg_grp_output_enable[i];
        end
      end
      dbg_pull_en_o <= dbg_grp_pull_enable & ~dbg_grp_mode_select;
      dbg_pull_up_o <= dbg_grp_pull_direction & `PCD_D_MASK_NOP2;
      dbg_fn_in_o <= d_sync & dbg_grp_mode_select;
    end
  end
endmodule // pcd_port

// [dv/pcd_checker.sv]
`timescale 1ns/1ns
`include "pcd_consts.vh"
module pcd_checker #(
  parameter [1:0] PKG = `PCD_PKG_100
) (
  input wire logic ref_clk_i, // Clock
  input wire logic rstn_i, // Reset, low
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [15:0] rdata_o, // Read data
  input wire logic irq_o, // Interrupt
  input wire logic [7:0] grp_c_pin_i, // C levels
  input wire logic [7:0] grp_c_pin_o, // C drive
  input wire logic [7:0] grp_c_pin_oe_o, // C enable
  input wire logic [7:0] grp_c_pull_en_o, // C pull
  input wire logic [15:0] grp_c_function_select_o, // C fields
  input wire logic [4:0] dbg_pin_o, // D drive
  input wire logic [4:0] dbg_pin_oe_o, // D enable
  input wire logic [4:0] dbg_pull_en_o, // D pull
  input wire logic [19:0] dbg_fn_out_i, // D fn drive
  input wire logic [19:0] dbg_fn_oe_i, // D fn enable
  input wire logic grp_c_group_irq_o // C summary
);
  localparam [7:0] LIVE = (PKG == `PCD_PKG_64) ? 8'h00 : (PKG == `PCD_PKG_80) ? 8'h1f : 8'hff;
  logic [7:0] prev_pin;
  logic [3:0] since_chg;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Age of the latest group C pin movement, saturating
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_pin <= 8'h00;
      since_chg <= 4'hf;
    end else begin
      prev_pin <= grp_c_pin_i;
      since_chg <= (grp_c_pin_i != prev_pin) ? 4'h0 : (since_chg == 4'hf) ? 4'hf : since_chg + 4'h1;
    end
  end
  // A cycle that did not follow a read
  sequence s_no_read;
    !rd_i ##1 1'b1;
  endsequence
  // Port behaviour tied to register state and pin events
  a_rdata_quiet: assert property (s_no_read |-> rdata_o == 16'h0000)
    else $error("read data without a read");
  a_fn_fixed: assert property (grp_c_function_select_o == `PCD_FNC_C_RO)
    else $error("group C function fields moved");
  a_p2_no_pull: assert property (dbg_pull_en_o[2] == 1'b0)
    else $error("pull on debug port two");
  a_c_reserved: assert property (((grp_c_pin_o | grp_c_pin_oe_o | grp_c_pull_en_o) & ~LIVE) == 8'h00)
    else $error("absent group C pin active");
  a_dbg_link_reset: assert property ($rose(rstn_i) |-> ##1 (dbg_pin_o[2:0] ==
    {dbg_fn_out_i[8], dbg_fn_out_i[4], dbg_fn_out_i[0]} && dbg_pin_oe_o[2:0] ==
    {dbg_fn_oe_i[8], dbg_fn_oe_i[4], dbg_fn_oe_i[0]}))
    else $error("debug link not on ports 2:0 after reset");
  a_grp_cause: assert property ($rose(grp_c_group_irq_o) |-> since_chg <= 4'h6 || $past(wr_i))
    else $error("group request without pin edge");
  a_grp_fall: assert property ($fell(grp_c_group_irq_o) |-> $past(wr_i))
    else $error("group request dropped without write");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(rd_i) || $past(wr_i))
    else $error("interrupt dropped without access");
  a_irq_rise: assert property ($rose(irq_o) |-> $past(grp_c_group_irq_o) || $past(wr_i))
    else $error("interrupt raised without cause");
endmodule // pcd_checker
bind pcd_port pcd_checker #(.PKG(PKG)) u_chk (.*);

// [dv/pcd_pins_model.sv]
`timescale 1ns/1ns
module pcd_pins_model #(
  parameter W = 8,
  parameter [4*W-1:0] FN_OUT = '0,
  parameter [4*W-1:0] FN_OE = '0
) (
  input wire logic ref_clk_i, // Clock
  input wire logic [W-1:0] drv_i, // Block drive value
  input wire logic [W-1:0] oe_i, // Block drive enable
  input wire logic [W-1:0] pen_i, // Pull enable
  input wire logic [W-1:0] pup_i, // Pull direction
  input wire logic [W-1:0] ext_i, // Outside level
  input wire logic [W-1:0] ext_en_i, // Outside driver on
  output logic [W-1:0] level_o, // Pin level
  output logic [4*W-1:0] fn_out_o, // Peripheral drive
  output logic [4*W-1:0] fn_oe_o // Peripheral enable
);
  logic [W-1:0] flt = '0;
  // Undriven, unpulled pins wander every cycle
  always @(posedge ref_clk_i) begin
    flt <= ~flt;
  end
  // Block drive, then outside driver, then pull, then floating
  assign level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i) | (~oe_i & ~ext_en_i & pen_i & pup_i)
    | (~oe_i & ~ext_en_i & ~pen_i & flt);
  assign fn_out_o = FN_OUT;
  assign fn_oe_o = FN_OE;
endmodule // pcd_pins_model

// [dv/pcd_port_bench.sv]
`timescale 1ns/1ns
`include "pcd_consts.vh"
module pcd_port_bench;
  localparam [31:0] C_FN_OUT = 32'h5a3c96e5;
  localparam [31:0] C_FN_OE = 32'hf0f0ff0f;
  localparam [19:0] D_FN_OUT = 20'h9e6a5;
  localparam [19:0] D_FN_OE = 20'hf2ff7;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] c_ext = 8'h00;
  logic [4:0] d_ext = 5'h00;
  logic [4:0] d_een = 5'h1f;
  wire [15:0] rdata_o, rd_b, grp_c_function_select_o;
  wire irq_o, irq_b, grp_c_group_irq_o, grp_b;
  wire [7:0] grp_c_pin_i, grp_c_pin_o, grp_c_pin_oe_o, grp_c_pull_en_o, grp_c_pull_up_o;
  wire [7:0] pin_b, out_b, oe_b, pe_b, pu_b;
  wire [31:0] grp_c_fn_out_i, grp_c_fn_oe_i;
  wire [4:0] dbg_pin_i, dbg_pin_o, dbg_pin_oe_o, dbg_pull_en_o, dbg_pull_up_o, dbg_fn_in_o;
  wire [19:0] dbg_fn_out_i, dbg_fn_oe_i;
  int bad_count = 0;
  int comparisons = 0;
  // Address, write data, readback of the full and the mid package build
  logic [51:0] rows [0:9] = '{52'h1_ff00_ff00_1f00, 52'h2_e0e0_e0e0_0000, 52'h4_e0e0_e0e0_0000,
    52'h6_00e0_00e0_0000, 52'h5_ffff_0000_0000, 52'h7_0000_aaaa_aaaa, 52'h9_ffff_1f1f_1f1f,
    52'hb_ffff_0000_0000, 52'hc_ffff_001f_001f, 52'hd_ffff_03ff_03ff};
  pcd_port u_dut (.*);
  pcd_port #(.PKG(`PCD_PKG_80)) u_dut80 (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rd_b), .irq_o(irq_b), .grp_c_pin_i(pin_b),
    .grp_c_pin_o(out_b), .grp_c_pin_oe_o(oe_b), .grp_c_pull_en_o(pe_b), .grp_c_pull_up_o(pu_b),
    .grp_c_function_select_o(), .grp_c_fn_out_i(grp_c_fn_out_i), .grp_c_fn_oe_i(grp_c_fn_oe_i),
    .dbg_pin_i(dbg_pin_i), .dbg_pin_o(), .dbg_pin_oe_o(), .dbg_pull_en_o(), .dbg_pull_up_o(),
    .dbg_fn_in_o(), .dbg_fn_out_i(dbg_fn_out_i), .dbg_fn_oe_i(dbg_fn_oe_i), .grp_c_group_irq_o(grp_b));
  wire [15:0] rd_c;
  // Smallest package build, group C absent
  pcd_port #(.PKG(`PCD_PKG_64)) u_dut64 (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rd_c), .irq_o(), .grp_c_pin_i(grp_c_pin_i),
    .grp_c_pin_o(), .grp_c_pin_oe_o(), .grp_c_pull_en_o(), .grp_c_pull_up_o(),
    .grp_c_function_select_o(), .grp_c_fn_out_i(grp_c_fn_out_i), .grp_c_fn_oe_i(grp_c_fn_oe_i),
    .dbg_pin_i(dbg_pin_i), .dbg_pin_o(), .dbg_pin_oe_o(), .dbg_pull_en_o(), .dbg_pull_up_o(),
    .dbg_fn_in_o(), .dbg_fn_out_i(dbg_fn_out_i), .dbg_fn_oe_i(dbg_fn_oe_i), .grp_c_group_irq_o());
  pcd_pins_model #(.W(8), .FN_OUT(C_FN_OUT), .FN_OE(C_FN_OE)) u_c_pins (.ref_clk_i(ref_clk_i),
    .drv_i(grp_c_pin_o), .oe_i(grp_c_pin_oe_o), .pen_i(grp_c_pull_en_o), .pup_i(grp_c_pull_up_o),
    .ext_i(c_ext), .ext_en_i(8'hff), .level_o(grp_c_pin_i), .fn_out_o(grp_c_fn_out_i), .fn_oe_o(grp_c_fn_oe_i));
  pcd_pins_model #(.W(8)) u_c_pins80 (.ref_clk_i(ref_clk_i), .drv_i(out_b), .oe_i(oe_b), .pen_i(pe_b),
    .pup_i(pu_b), .ext_i(c_ext), .ext_en_i(8'hff), .level_o(pin_b), .fn_out_o(), .fn_oe_o());
  pcd_pins_model #(.W(5), .FN_OUT(D_FN_OUT), .FN_OE(D_FN_OE)) u_d_pins (.ref_clk_i(ref_clk_i),
    .drv_i(dbg_pin_o), .oe_i(dbg_pin_oe_o), .pen_i(dbg_pull_en_o), .pup_i(dbg_pull_up_o),
    .ext_i(d_ext), .ext_en_i(d_een), .level_o(dbg_pin_i), .fn_out_o(dbg_fn_out_i), .fn_oe_o(dbg_fn_oe_i));
  // Clock, 8 ns period
  always #4 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] da, output logic [15:0] db);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    da = rdata_o;
    db = rd_b;
  endtask
  task automatic wait_grp;
    for (int i = 0; i < 20 && grp_c_group_irq_o !== 1'b1; i++) tick();
    chk("group_irq", 16'h0001, {15'h0, grp_c_group_irq_o});
    if (grp_c_group_irq_o !== 1'b1) wrap_up();
  endtask
  // Main sequence: reset values, register table, then hand-written cases
  initial begin
    logic [15:0] ra;
    logic [15:0] rb;
    logic [15:0] ex;
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      ex = (a == 7) ? 16'haaaa : (a == 12) ? 16'h0007 : 16'h0000;
      rd(4'(a), ra, rb);
      chk("reset_value", ex, ra);
      chk("reset_value_mid", ex, rb);
      chk("reset_value_small", ex, rd_c);
    end
    for (int r = 0; r < 10; r++) begin
      wr(rows[r][51:48], rows[r][47:32]);
      rd(rows[r][51:48], ra, rb);
      chk("register", rows[r][31:16], ra);
      chk("register_mid", rows[r][15:0], rb);
      chk("register_small", (rows[r][51:48] < 4'h7) ? 16'h0000 : rows[r][31:16], rd_c);
    end
    wr(4'h6, 16'h0000);
    wr(4'h2, 16'h3c5a);
    wr(4'h1, 16'h00ff);
    wr(4'h0, 16'h5a00);
    tick();
    chk("c_drive", 16'h5aff, {grp_c_pin_o, grp_c_pin_oe_o});
    chk("c_drive_mid", 16'h1a1f, {out_b, oe_b});
    chk("c_pull", 16'h3c5a, {grp_c_pull_up_o, grp_c_pull_en_o});
    chk("c_pull_mid", 16'h1c1a, {pu_b, pe_b});
    wr(4'h1, 16'hffff);
    tick();
    rd(4'h0, ra, rb);
    chk("c_data", 16'h5a5a, ra);
    chk("c_data_mid", 16'h1a1a, rb);
    wr(4'h6, 16'h0001);
    tick();
    chk("c_function", {14'h0, C_FN_OE[2], C_FN_OUT[2]}, {14'h0, grp_c_pin_oe_o[0], grp_c_pin_o[0]});
    wr(4'hd, 16'h0040);
    wr(4'hc, 16'h0008);
    tick();
    chk("d_mix", {6'h0, 1'b1, D_FN_OE[13], 3'h7, 1'b0, D_FN_OUT[13], 3'h0}, {6'h0, dbg_pin_oe_o, dbg_pin_o});
    repeat (3) tick();
    chk("d_fn_in", {11'h0, D_FN_OE[13] & D_FN_OUT[13], 3'h0}, {11'h0, dbg_fn_in_o});
    @(posedge ref_clk_i);
    d_een <= 5'h00;
    wr(4'hc, 16'h0000);
    wr(4'h9, 16'h1f00);
    wr(4'ha, 16'h1f1f);
    repeat (3) tick();
    rd(4'h8, ra, rb);
    chk("d_input", 16'h001b, ra);
    chk("d_pull", 16'h001b, {11'h0, dbg_pull_en_o});
    chk("d_pull_dir", 16'h001b, {11'h0, dbg_pull_up_o});
    wr(4'h6, 16'h0000);
    wr(4'h1, 16'hff00);
    wr(4'h4, 16'h02a3);
    wr(4'hf, 16'h0000);
    wr(4'h3, 16'hffff);
    rd(4'he, ra, rb);
    @(posedge ref_clk_i);
    c_ext <= 8'h82;
    wait_grp();
    rd(4'h3, ra, rb);
    chk("flags", 16'h0080, ra);
    chk("flags_mid", 16'h0000, rb);
    chk("irq_masked", 16'h0000, {15'h0, irq_o});
    wr(4'hf, 16'h0008);
    tick();
    chk("irq_unmasked", 16'h0001, {15'h0, irq_o});
    wr(4'h3, 16'h0000);
    rd(4'h3, ra, rb);
    chk("flag_kept", 16'h0080, ra);
    wr(4'h3, 16'h0080);
    rd(4'h3, ra, rb);
    chk("flag_cleared", 16'h0000, ra);
    rd(4'he, ra, rb);
    chk("status", 16'h0008, ra);
    tick();
    chk("irq_cleared", 16'h0000, {15'h0, irq_o});
    @(posedge ref_clk_i);
    c_ext <= 8'h80;
    wait_grp();
    rd(4'h3, ra, rb);
    chk("falling", 16'h0002, ra);
    chk("falling_mid", 16'h0002, rb);
    wrap_up();
  end
endmodule // pcd_port_bench
